// *** hw/pixel_freq_counter_and_caps.sv ***
// Added by the designer: strobed register access.
`timescale 1ns/100ps

module pixel_freq_counter_and_caps
  import pfc_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DIV_W  = 4
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,

  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,

  // Pixel clock pin, sampled
  input  wire logic              pixel_clk_pin,

  // Back channel capability load
  input  wire logic              rx_lock,
  input  wire logic              caps_load_valid,
  input  wire logic [5:0]        caps_load_data,

  // Capability and training outputs
  output logic                   freq_training_request,
  output logic                   equalizer_training_request,
  output logic                   two_link_capable,
  output logic                   channel_index,
  output logic                   partner_vid24_hd_audio,
  output logic                   partner_fc_gpio,
  output logic                   hold_partner_capabilities,

  // Measurement status
  output logic                   measure_busy
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic              pix_edge;

  logic [DIV_W-1:0]  osc_div_reg;
  logic              osc_tick;

  meas_state_t       meas_state_reg;
  logic [7:0]        window_left_reg;
  logic [7:0]        edge_count_reg;

  logic [7:0]        caps_reg;
  logic [7:0]        caps_next;

  logic              wr_counter;
  logic              wr_caps;
  logic              load_ok;

  logic [DATA_W-1:0] rdata_next;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV_CYCLES - 1);

  // ****************************************************
  // Address decode
  // ****************************************************

  // Write strobes per register
  assign wr_counter = reg_wr && (reg_addr == ADDR_EDGE_COUNTER);
  assign wr_caps    = reg_wr && (reg_addr == ADDR_CAPS_ONE);

  // ****************************************************
  // Pixel clock sampling
  // ****************************************************

  // Settled pin and its rising edges
  pin_rise_detect #(
    .WIDTH (1)
  ) pixel_sampler (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin_async (pixel_clk_pin),
    .pin_rise  (pix_edge)
  );

  // ****************************************************
  // Oscillator period divider
  // ****************************************************

  // Restarted by a counter write so the first period is whole
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_div_reg <= '0;
    end else if (wr_counter || osc_tick) begin
      osc_div_reg <= '0;
    end else begin
      osc_div_reg <= osc_div_reg + DIV_W'(1);
    end
  end

  // One-cycle pulse per oscillator period
  assign osc_tick = (osc_div_reg == DIV_LAST);

  // ****************************************************
  // Measurement sequencing
  // ****************************************************

  // Idle until a nonzero counter write, run for the programmed periods
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meas_state_reg <= MEAS_IDLE;
    end else begin
      case (meas_state_reg)
        MEAS_IDLE: begin
          if (wr_counter && (reg_wdata[7:0] != 8'h00)) begin
            meas_state_reg <= MEAS_RUN;
          end
        end
        MEAS_RUN: begin
          if (wr_counter && (reg_wdata[7:0] == 8'h00)) begin
            meas_state_reg <= MEAS_IDLE;
          end else if (!wr_counter && osc_tick && (window_left_reg == 8'h01)) begin
            meas_state_reg <= MEAS_IDLE;
          end
        end
        default: begin
          meas_state_reg <= MEAS_IDLE;
        end
      endcase
    end
  end

  // Remaining oscillator periods in the window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      window_left_reg <= 8'h00;
    end else if (wr_counter) begin
      window_left_reg <= reg_wdata[7:0];
    end else if ((meas_state_reg == MEAS_RUN) && osc_tick) begin
      window_left_reg <= window_left_reg - 8'h01;
    end
  end

  // ****************************************************
  // Edge counter
  // ****************************************************

  // Cleared on start, counts edges while running, sticks at max
  sat_up_counter #(
    .WIDTH (8),
    .START (RST_EDGE_COUNT),
    .TOP   (COUNT_MAX)
  ) edge_counter (
    .core_clk  (core_clk),
    .rst       (rst),
    .clear     (wr_counter),
    .step      ((meas_state_reg == MEAS_RUN) && pix_edge),
    .count_reg (edge_count_reg)
  );

  assign measure_busy = (meas_state_reg == MEAS_RUN);

  // ****************************************************
  // Capability register
  // ****************************************************

  // Back channel may load only after lock and while not held
  assign load_ok = caps_load_valid && rx_lock && !caps_reg[BIT_HOLD];

  // A write that sets hold beats a same-cycle load
  always_comb begin
    caps_next = caps_reg;
    if (wr_caps) begin
      caps_next = reg_wdata[7:0] & CAPS_RW_MASK;
    end
    if (load_ok && !(wr_caps && reg_wdata[BIT_HOLD])) begin
      caps_next = (caps_next & ~CAPS_LOAD_MASK) | {2'b00, caps_load_data};
    end
  end

  // Capability storage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      caps_reg <= RST_CAPS_ONE;
    end else begin
      caps_reg <= caps_next;
    end
  end

  // ****************************************************
  // Capability outputs
  // ****************************************************

  // Fields drive the link logic directly
  assign hold_partner_capabilities  = caps_reg[BIT_HOLD];
  assign freq_training_request      = caps_reg[BIT_FREQ_TRAIN];
  assign equalizer_training_request = caps_reg[BIT_EQ_TRAIN];
  assign two_link_capable           = caps_reg[BIT_TWO_LINK];
  assign channel_index              = caps_reg[BIT_CHANNEL];
  assign partner_vid24_hd_audio     = caps_reg[BIT_VID24_AUD];
  assign partner_fc_gpio            = caps_reg[BIT_FC_GPIO];

  // ****************************************************
  // Read path
  // ****************************************************

  // Read mux; unmapped and reserved read as zero
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_EDGE_COUNTER: begin
          rdata_next[7:0] = edge_count_reg;
        end
        ADDR_CAPS_ONE: begin
          rdata_next[7:0] = caps_reg;
        end
        ADDR_CAPS_TWO: begin
          rdata_next[7:0] = 8'h00;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule : pixel_freq_counter_and_caps

// ****************************************************
// Pin synchroniser with rising edge detect
// ****************************************************

// Two flops settle the pin, a third remembers the last level
module pin_rise_detect #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,

  // Asynchronous pin and its rising edges
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_rise
);

  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] prev_reg;

  // Only the second stage reads the first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
    end
  end

  // Delayed copy for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  // High now and low one cycle ago
  assign pin_rise = sync2_reg & ~prev_reg;

endmodule : pin_rise_detect

// ****************************************************
// Saturating up-counter
// ****************************************************

// Clear wins over a step; the count sticks at its top value
module sat_up_counter #(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] START = '0,
  parameter logic [WIDTH-1:0] TOP   = '1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,

  // Control
  input  wire logic             clear,
  input  wire logic             step,

  // Present count
  output logic      [WIDTH-1:0] count_reg
);

  // Count register, never wraps
  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count_reg <= START;
    end else if (step && (count_reg != TOP)) begin
      count_reg <= count_reg + WIDTH'(1);
    end
  end

endmodule : sat_up_counter

// *** inc/pfc_pkg.sv ***
package pfc_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ADDR_EDGE_COUNTER = 8'h1F;
  localparam logic [7:0] ADDR_CAPS_ONE     = 8'h20;
  localparam logic [7:0] ADDR_CAPS_TWO     = 8'h21;

  // ****************************************************
  // Capability field positions
  // ****************************************************
  localparam int BIT_HOLD       = 7;
  localparam int BIT_FREQ_TRAIN = 5;
  localparam int BIT_EQ_TRAIN   = 4;
  localparam int BIT_TWO_LINK   = 3;
  localparam int BIT_CHANNEL    = 2;
  localparam int BIT_VID24_AUD  = 1;
  localparam int BIT_FC_GPIO    = 0;

  // Loadable fields (bits 5..0) and reserved bit 6
  localparam logic [7:0] CAPS_LOAD_MASK = 8'h3F;
  localparam logic [7:0] CAPS_RW_MASK   = 8'hBF;

  // ****************************************************
  // Reset values and edge count top
  // ****************************************************
  localparam logic [7:0] RST_EDGE_COUNT = 8'h00;
  localparam logic [7:0] RST_CAPS_ONE   = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hFF;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_PERIOD_NS  = 20;
  localparam int OSC_PERIOD_NS  = 40;
  localparam int OSC_DIV_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************
  // Measurement states
  // ****************************************************
  typedef enum logic [0:0] {
    MEAS_IDLE = 1'b0,
    MEAS_RUN  = 1'b1
  } meas_state_t;

endpackage : pfc_pkg

// *** verif/pfc_chk.sv ***
`timescale 1ns/100ps
module pfc_chk
  import pfc_pkg::*;
#(parameter int DATA_W = 8) (
  // Clock, reset and register port
  input wire logic              core_clk, rst, reg_wr, reg_rd, pixel_clk_pin,
  input wire logic [7:0]        reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
  // Back channel and outputs
  input wire logic rx_lock, caps_load_valid, measure_busy, hold_partner_capabilities,
  input wire logic [5:0] caps_load_data,
  input wire logic freq_training_request, equalizer_training_request, two_link_capable,
  input wire logic channel_index, partner_vid24_hd_audio, partner_fc_gpio
);
  // ****
  // Window and capability checks
  // ****
  wire logic [5:0] caps = {freq_training_request, equalizer_training_request,
    two_link_capable, channel_index, partner_vid24_hd_audio, partner_fc_gpio};
  wire logic hold = hold_partner_capabilities;
  wire logic wr_cnt = reg_wr && reg_addr == ADDR_EDGE_COUNTER;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // One tick window: two busy cycles then idle
  sequence s_two; measure_busy ##1 measure_busy ##1 !measure_busy; endsequence
  property p_start; wr_cnt && reg_wdata != 0 |=> measure_busy; endproperty
  a_start: assert property (p_start) else $error("busy missing");
  property p_win; wr_cnt && reg_wdata == 8'h01 |=> s_two; endproperty
  a_win: assert property (p_win) else $error("window length wrong");
  property p_zero; wr_cnt && reg_wdata == 0 |=> !measure_busy; endproperty
  a_zero: assert property (p_zero) else $error("empty window ran");
  property p_rd_caps; reg_rd && reg_addr == ADDR_CAPS_ONE |=>
    reg_rdata == $past({hold, 1'b0, caps}); endproperty
  a_rd_caps: assert property (p_rd_caps) else $error("caps read wrong");
  property p_rd_res; reg_rd && reg_addr == ADDR_CAPS_TWO |=> reg_rdata == 0; endproperty
  a_rd_res: assert property (p_rd_res) else $error("reserved read");
  property p_wr_caps; reg_wr && reg_addr == ADDR_CAPS_ONE && !caps_load_valid |=>
    {hold, caps} == $past({reg_wdata[7], reg_wdata[5:0]}); endproperty
  a_wr_caps: assert property (p_wr_caps) else $error("caps write lost");
  property p_load; caps_load_valid && rx_lock && !hold && !reg_wr |=>
    caps == $past(caps_load_data); endproperty
  a_load: assert property (p_load) else $error("load missed");
  property p_nolock; caps_load_valid && !rx_lock && !reg_wr |=> $stable(caps); endproperty
  a_nolock: assert property (p_nolock) else $error("load without lock");
  property p_hold; caps_load_valid && hold && !reg_wr |=> $stable({hold, caps}); endproperty
  a_hold: assert property (p_hold) else $error("held caps changed");
  property p_rd_idle; !reg_rd |=> reg_rdata == 0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_hold_wins; reg_wr && reg_addr == ADDR_CAPS_ONE && reg_wdata[7] |=>
    {hold, caps} == $past({reg_wdata[7], reg_wdata[5:0]}); endproperty
  a_hold_wins: assert property (p_hold_wins) else $error("hold write lost");
endmodule : pfc_chk

// *** verif/deser_model.sv ***
`timescale 1ns/100ps
module deser_model (
  // Clock, reset and bench requests
  input wire logic       core_clk, rst, lock_in, send,
  input wire logic [5:0] cap,
  // Back channel toward the block
  output logic           rx_lock, caps_load_valid,
  output logic [5:0]     caps_load_data
);
  // Lock follows request; one beat per send, idle data flips each cycle
  always_ff @(posedge core_clk) begin
    rx_lock         <= !rst && lock_in;
    caps_load_valid <= !rst && send;
    caps_load_data  <= rst ? 6'h2A : send ? cap : ~caps_load_data;
  end
endmodule : deser_model

// *** verif/pixel_freq_counter_and_caps_tb.sv ***
`timescale 1ns/100ps
module pixel_freq_counter_and_caps_tb;
  import pfc_pkg::*;
  // ****
  // Stimulus, partner and bookkeeping
  // ****
  logic       core_clk, rst, reg_wr, reg_rd, pixel_clk_pin, lock_in, send;
  logic       rx_lock, caps_load_valid, measure_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] cap, caps_load_data;
  wire  [6:0] caps_out; // Hold bit on top of bits 5..0
  logic [1:0] pix_half;
  int         failures, samples_checked, pcnt;
  pixel_freq_counter_and_caps uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pixel_clk_pin, .rx_lock, .caps_load_valid, .caps_load_data,
    .freq_training_request(caps_out[5]), .equalizer_training_request(caps_out[4]),
    .two_link_capable(caps_out[3]), .channel_index(caps_out[2]),
    .partner_vid24_hd_audio(caps_out[1]), .partner_fc_gpio(caps_out[0]),
    .hold_partner_capabilities(caps_out[6]), .measure_busy);
  deser_model partner (.core_clk, .rst, .lock_in, .send, .cap, .rx_lock,
    .caps_load_valid, .caps_load_data);
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // Pixel source, toggled every pix_half core cycles
  always @(posedge core_clk) begin
    pcnt <= pcnt + 1;
    if (pix_half != 0 && pcnt % pix_half == 0) pixel_clk_pin <= ~pixel_clk_pin;
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_wr    <= 1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, exp, input string what);
    @(posedge core_clk);
    reg_rd   <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk(what, reg_rdata, exp);
  endtask : rdchk
  task automatic send_caps(input logic [5:0] c);
    @(posedge core_clk);
    send <= 1;
    cap  <= c;
    @(posedge core_clk);
    send <= 0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : send_caps
  task automatic t_measure();
    logic [7:0] n [4] = '{8'h08, 8'hFF, 8'h01, 8'h00};
    logic [1:0] h [4] = '{2'd2, 2'd1, 2'd1, 2'd1};
    int cyc;
    for (int i = 0; i < 4; i++) begin
      pix_half <= h[i];
      repeat (4) @(posedge core_clk);
      wr(ADDR_EDGE_COUNTER, n[i]);
      chk("busy", measure_busy, n[i] != 0);
      cyc = 0;
      while (measure_busy === 1'b1 && cyc < 600) begin
        @(posedge core_clk);
        #1 cyc++;
      end
      chk("window", cyc, 2 * n[i]);
      rdchk(ADDR_EDGE_COUNTER, n[i] / h[i], "edges");
    end
    $display("test measure done");
  endtask : t_measure
  task automatic t_caps();
    logic [7:0] pat [3] = '{8'hB4, 8'h7F, 8'h0B};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CAPS_ONE, pat[i]);
      chk("caps pins", {caps_out[6], 1'b0, caps_out[5:0]}, pat[i] & CAPS_RW_MASK);
      rdchk(ADDR_CAPS_ONE, pat[i] & CAPS_RW_MASK, "caps reg");
    end
    wr(ADDR_CAPS_TWO, 8'hFF);
    rdchk(ADDR_CAPS_TWO, 8'h00, "caps two");
    rdchk(8'h55, 8'h00, "unmapped");
    $display("test caps done");
  endtask : t_caps
  task automatic t_load();
    wr(ADDR_CAPS_ONE, 8'h00);
    lock_in <= 1;
    send_caps(6'h2A);
    rdchk(ADDR_CAPS_ONE, 8'h2A, "loaded");
    lock_in <= 0;
    send_caps(6'h15);
    chk("no lock", caps_out, 7'h2A);
    wr(ADDR_CAPS_ONE, 8'h95);
    lock_in <= 1;
    send_caps(6'h2A);
    rdchk(ADDR_CAPS_ONE, 8'h95, "held");
    $display("test load done");
  endtask : t_load
  task automatic t_collide();
    logic [7:0] w [2] = '{8'h24, 8'hA4};
    logic [7:0] e [2] = '{8'h3F, 8'hA4};
    wr(ADDR_CAPS_ONE, 8'h00);
    for (int i = 0; i < 2; i++) begin
      fork
        send_caps(6'h3F);
        begin
          @(posedge core_clk);
          wr(ADDR_CAPS_ONE, w[i]);
        end
      join
      rdchk(ADDR_CAPS_ONE, e[i], "collide");
    end
    $display("test collide done");
  endtask : t_collide
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // Main sequence after 16 reset cycles
  initial begin
    {rst, reg_wr, reg_rd, pixel_clk_pin, lock_in, send} = 6'b100000;
    {reg_addr, reg_wdata, cap, pix_half, pcnt} = '0;
    {failures, samples_checked} = '0;
    repeat (16) @(posedge core_clk);
    rst <= 0;
    rdchk(ADDR_EDGE_COUNTER, RST_EDGE_COUNT, "count rst");
    rdchk(ADDR_CAPS_ONE, RST_CAPS_ONE, "caps rst");
    t_measure();
    t_caps();
    t_load();
    t_collide();
    results();
  end
  // Watchdog, well beyond the roughly 630 cycles the tests take
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    results();
  end
endmodule : pixel_freq_counter_and_caps_tb
bind pixel_freq_counter_and_caps pfc_chk #(.DATA_W(DATA_W)) chk_i (.core_clk, .rst,
  .reg_wr, .reg_rd, .pixel_clk_pin, .reg_addr, .reg_wdata, .reg_rdata, .rx_lock,
  .caps_load_valid, .measure_busy, .hold_partner_capabilities, .caps_load_data,
  .freq_training_request, .equalizer_training_request, .two_link_capable,
  .channel_index, .partner_vid24_hd_audio, .partner_fc_gpio);
